// ---- core/ppsi_top.sv ----
// printer port signal interface: strobe sequencer, control lines, status sync, interrupt
// What this block does
// - in printer mode, interrupt follows acknowledge
// - strobe pulses low with data held valid
// - auto-feed low requests continuous paper feed
// - initialise low commands a peripheral reset
// - select low selects the peripheral
// - interrupt open drain, driven low when active
`timescale 1ns/10ps
`default_nettype none
module ppsi_top (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire ppsi_pkg::ppsi_ctl_t ctl,
	input wire logic [ppsi_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire ppsi_pkg::ppsi_status_t status_pins,
	input wire logic [ppsi_pkg::DATA_W-1:0] data_pins_in,
	output logic [ppsi_pkg::DATA_W-1:0] data_pins_out,
	output logic data_pins_oe,
	output var ppsi_pkg::ppsi_status_t status_sync,
	output logic [ppsi_pkg::DATA_W-1:0] data_sampled,
	output logic tx_active,
	output logic data_strobe_out_n,
	output logic data_strobe_oe,
	output logic auto_feed_out_n,
	output logic auto_feed_oe,
	output logic init_out_n,
	output logic init_oe,
	output logic select_out_n,
	output logic select_oe,
	output logic host_interrupt_out_n,
	output logic host_interrupt_oe
);
	import ppsi_pkg::*;

	// interrupt is armed only in printer mode with its enable set
	function automatic logic irq_armed(input ppsi_ctl_t c);
		return c.standard_printer_mode && c.irq_enable;
	endfunction : irq_armed

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers: first stage is read only by the second
	ppsi_status_t status_meta_q, status_meta_d, status_q, status_d;
	logic [DATA_W-1:0] din_meta_q, din_meta_d, din_q, din_d;

	always_comb begin
		status_meta_d = status_pins;
		status_d = status_meta_q;
		din_meta_d = data_pins_in;
		din_d = din_meta_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			status_meta_q <= STATUS_RST;
			status_q <= STATUS_RST;
			din_meta_q <= DATA_RST;
			din_q <= DATA_RST;
		end else begin
			status_meta_q <= status_meta_d;
			status_q <= status_d;
			din_meta_q <= din_meta_d;
			din_q <= din_d;
		end
	end

	assign status_sync = status_q;
	assign data_sampled = din_q;

	////////////////////////////////////////////////////////////////////////////////
	// byte buffer; back-pressure reaches the user through wr_ready
	logic [DATA_W-1:0] fifo_data;
	logic fifo_valid, fifo_take;

	ppsi_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) ppsi_fifo_inst (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.in_data(wr_data),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_take)
	);

	////////////////////////////////////////////////////////////////////////////////
	// strobe sequencer and pin drivers
	ppsi_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [DATA_W-1:0] dout_q, dout_d;
	logic dout_oe_q, dout_oe_d;
	logic strobe_oe_q, strobe_oe_d, feed_oe_q, feed_oe_d;
	logic init_oe_q, init_oe_d, sel_oe_q, sel_oe_d, irq_oe_q, irq_oe_d;
	logic tx_q, tx_d;
	logic [4:0] lvl_n_q, lvl_n_d;
	logic busy_s;

	always_comb begin
		busy_s = status_q.peripheral_not_ready_in;
		state_d = state_q;
		cnt_d = cnt_q;
		dout_d = dout_q;
		fifo_take = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// busy is sampled before each byte only; a busy rise mid-pulse is ignored
				if (fifo_valid && !busy_s && !ctl.dir_input) begin
					fifo_take = 1'b1;
					dout_d = fifo_data;
					cnt_d = CNT_W'(SETUP_CYC - 1'b1);
					state_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cnt_q == '0) begin
					cnt_d = CNT_W'(PULSE_CYC - 1'b1);
					state_d = ST_PULSE;
				end else begin
					cnt_d = CNT_W'(cnt_q - 1'b1);
				end
			end
			ST_PULSE: begin
				if (cnt_q == '0) begin
					cnt_d = CNT_W'(HOLD_CYC - 1'b1);
					state_d = ST_HOLD;
				end else begin
					cnt_d = CNT_W'(cnt_q - 1'b1);
				end
			end
			ST_HOLD: begin
				if (cnt_q == '0) begin
					state_d = ST_IDLE;
				end else begin
					cnt_d = CNT_W'(cnt_q - 1'b1);
				end
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d = '0;
			end
		endcase
		// a byte in flight keeps the bus driven even if direction flips
		dout_oe_d = !ctl.dir_input || (state_d != ST_IDLE);
		strobe_oe_d = (state_d == ST_PULSE);
		feed_oe_d = ctl.auto_feed;
		init_oe_d = ctl.init;
		sel_oe_d = ctl.select;
		irq_oe_d = irq_armed(ctl) && !status_q.transfer_ack_in_n;
		// pin levels get flops of their own so that every output leaves a register
		tx_d = (state_d != ST_IDLE);
		lvl_n_d = ~{strobe_oe_d, feed_oe_d, init_oe_d, sel_oe_d, irq_oe_d};
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			dout_q <= DATA_RST;
			dout_oe_q <= 1'b0;
			strobe_oe_q <= 1'b0;
			feed_oe_q <= 1'b0;
			init_oe_q <= 1'b0;
			sel_oe_q <= 1'b0;
			irq_oe_q <= 1'b0;
			tx_q <= 1'b0;
			lvl_n_q <= 5'h1F;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			dout_q <= dout_d;
			dout_oe_q <= dout_oe_d;
			strobe_oe_q <= strobe_oe_d;
			feed_oe_q <= feed_oe_d;
			init_oe_q <= init_oe_d;
			sel_oe_q <= sel_oe_d;
			irq_oe_q <= irq_oe_d;
			tx_q <= tx_d;
			lvl_n_q <= lvl_n_d;
		end
	end

	// open-drain lines: the level output mirrors the enable, low while driven
	assign data_pins_out = dout_q;
	assign data_pins_oe = dout_oe_q;
	assign tx_active = tx_q;
	assign data_strobe_oe = strobe_oe_q;
	assign data_strobe_out_n = lvl_n_q[4];
	assign auto_feed_oe = feed_oe_q;
	assign auto_feed_out_n = lvl_n_q[3];
	assign init_oe = init_oe_q;
	assign init_out_n = lvl_n_q[2];
	assign select_oe = sel_oe_q;
	assign select_out_n = lvl_n_q[1];
	assign host_interrupt_oe = irq_oe_q;
	assign host_interrupt_out_n = lvl_n_q[0];

	////////////////////////////////////////////////////////////////////////////////
	// checks
	localparam int CHK_PULSE = int'(PULSE_CYC);
	localparam int CHK_SETUP = int'(SETUP_CYC);
	logic [1:0] since_rst_q;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			since_rst_q <= 2'h0;
		end else if (since_rst_q != 2'h3) begin
			since_rst_q <= 2'(since_rst_q + 1'b1);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_strobe_start;
		$rose(data_strobe_oe);
	endsequence

	sequence s_strobe_end;
		##CHK_PULSE $fell(data_strobe_oe);
	endsequence

	chk_strobe_width: assert property (s_strobe_start |-> s_strobe_end)
		else $error("strobe pulse width wrong");
	chk_strobe_data: assert property (data_strobe_oe |-> data_pins_oe && $stable(data_pins_out))
		else $error("data not held during strobe");
	chk_strobe_setup: assert property (s_strobe_start
		|-> $past(state_q, CHK_SETUP + 1) == ST_IDLE && $past(state_q, CHK_SETUP) == ST_SETUP)
		else $error("strobe setup time wrong");
	chk_busy_block: assert property (state_q == ST_IDLE && busy_s |=> state_q == ST_IDLE)
		else $error("byte started while busy");
	chk_irq_follow: assert property (irq_armed(ctl)
		|=> host_interrupt_oe == !$past(status_q.transfer_ack_in_n))
		else $error("interrupt does not follow acknowledge");
	chk_irq_release: assert property (!irq_armed(ctl)
		|=> !host_interrupt_oe && host_interrupt_out_n)
		else $error("interrupt driven while disabled");
	// the first edge after reset still sees control bits from inside reset
	chk_feed_line: assert property (since_rst_q != 2'h0
		|-> auto_feed_oe == $past(ctl.auto_feed) && auto_feed_out_n != auto_feed_oe)
		else $error("auto-feed line wrong");
	chk_init_line: assert property ($rose(ctl.init) |=> init_oe && !init_out_n)
		else $error("initialise line not driven");
	chk_select_line: assert property (!ctl.select |=> select_out_n && !select_oe)
		else $error("select line not released");
	chk_dir_release: assert property (ctl.dir_input && state_q == ST_IDLE |=> !data_pins_oe)
		else $error("data lines driven in input direction");
	chk_status_sync: assert property (since_rst_q == 2'h3 |-> status_sync == $past(status_pins, 2))
		else $error("status not two stages behind pins");

endmodule : ppsi_top
`default_nettype wire

// ---- pkg/ppsi_pkg.sv ----
// shared types and constants of the printer port signal interface
package ppsi_pkg;

	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int CNT_W = 8;

	// strobe timing, in ns, and the clock period they are counted against
	localparam int CLK_PERIOD_NS = 50;
	localparam int SETUP_NS = 500;
	localparam int PULSE_NS = 1000;
	localparam int HOLD_NS = 500;

	// least times round up to whole cycles
	localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// status pins have pull-ups, so they idle high
	localparam logic [4:0] STATUS_RST = 5'h1F;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	typedef struct packed {
		logic peripheral_selected_in;
		logic paper_empty_in;
		logic peripheral_not_ready_in;
		logic transfer_ack_in_n;
		logic peripheral_error_in_n;
	} ppsi_status_t;

	typedef struct packed {
		logic standard_printer_mode;
		logic irq_enable;
		logic auto_feed;
		logic init;
		logic select;
		logic dir_input;
	} ppsi_ctl_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SETUP,
		ST_PULSE,
		ST_HOLD
	} ppsi_state_t;

endpackage : ppsi_pkg

// ---- core/ppsi_fifo.sv ----
// byte FIFO with registered read data between the user and the strobe sequencer
`timescale 1ns/10ps
`default_nettype none
module ppsi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	import ppsi_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [AW:0] count_q, count_d;
	logic in_ready_q, in_ready_d;
	logic [WIDTH-1:0] out_data_q, out_data_d;
	logic out_valid_q, out_valid_d;
	logic push, pop_mem;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		push = in_valid && in_ready_q;
		// refill the output register whenever it is empty or being taken
		pop_mem = (count_q != '0) && (!out_valid_q || out_ready);
		wr_ptr_d = push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
		rd_ptr_d = pop_mem ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
		count_d = count_q;
		if (push && !pop_mem) begin
			count_d = (AW+1)'(count_q + 1'b1);
		end else if (!push && pop_mem) begin
			count_d = (AW+1)'(count_q - 1'b1);
		end
		in_ready_d = (count_d < (AW+1)'(DEPTH));
		out_data_d = pop_mem ? mem_q[rd_ptr_q] : out_data_q;
		out_valid_d = pop_mem || (out_valid_q && !out_ready);
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			in_ready_q <= 1'b0;
			out_data_q <= '0;
			out_valid_q <= 1'b0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
			in_ready_q <= in_ready_d;
			out_data_q <= out_data_d;
			out_valid_q <= out_valid_d;
		end
	end

	assign in_ready = in_ready_q;
	assign out_data = out_data_q;
	assign out_valid = out_valid_q;

endmodule : ppsi_fifo
`default_nettype wire

// ---- verif/ppsi_printer_model.sv ----
// behavioural printer on the far side of the port
`timescale 1ns/10ps
`default_nettype none
module ppsi_printer_model (
	input wire logic clk_sys,
	input wire logic strobe_n,
	input wire logic init_n,
	input wire logic [ppsi_pkg::DATA_W-1:0] data_wire,
	input wire logic hold_busy,
	input wire logic [7:0] busy_len,
	input wire logic [2:0] cond,
	output var ppsi_pkg::ppsi_status_t status,
	output logic [ppsi_pkg::DATA_W-1:0] pat,
	output logic cap_valid,
	output logic [ppsi_pkg::DATA_W-1:0] cap_data,
	output logic overrun
);
	import ppsi_pkg::*;
	logic stb_p = 1'b1;
	logic [7:0] busy_cnt = 8'h00;
	initial begin
		status = STATUS_RST;
		pat = 8'h5A;
		cap_valid = 1'b0;
		cap_data = 8'h00;
		overrun = 1'b0;
	end
	// undriven data lines float, so show a pattern that moves every cycle
	always @(posedge clk_sys) begin
		stb_p <= strobe_n;
		cap_valid <= 1'b0;
		pat <= pat + 8'h35;
		if (!stb_p && strobe_n) begin
			cap_valid <= 1'b1;
			cap_data <= data_wire;
			busy_cnt <= busy_len;
		end else if (busy_cnt != 8'h00)
			busy_cnt <= busy_cnt - 8'h01;
		if (stb_p && !strobe_n && status.peripheral_not_ready_in)
			overrun <= 1'b1;
		status.peripheral_not_ready_in <= hold_busy || !init_n || busy_cnt > 8'h01;
		status.transfer_ack_in_n <= !(busy_cnt > 8'h01 && busy_cnt < 8'h06);
		status.peripheral_selected_in <= !cond[0];
		status.paper_empty_in <= cond[1];
		status.peripheral_error_in_n <= !cond[2];
	end
endmodule : ppsi_printer_model
`default_nettype wire

// ---- verif/tb_ppsi_top.sv ----
// self-checking bench for the printer port signal interface
`timescale 1ns/10ps
`default_nettype none
module tb_ppsi_top;
	import ppsi_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	ppsi_ctl_t ctl = '0;
	logic [DATA_W-1:0] wr_data = 8'h00;
	logic wr_valid = 1'b0;
	logic hold_busy = 1'b0;
	logic [7:0] busy_len = 8'h08;
	logic [2:0] cond = 3'h0;
	logic wr_ready, data_pins_oe, tx_active, data_strobe_out_n, data_strobe_oe;
	logic auto_feed_out_n, auto_feed_oe, init_out_n, init_oe, select_out_n, select_oe;
	logic host_interrupt_out_n, host_interrupt_oe, cap_valid, overrun;
	logic [DATA_W-1:0] data_pins_out, data_sampled, pat, cap_data;
	ppsi_status_t status_pins, status_sync;
	wire logic [DATA_W-1:0] data_pins_in = data_pins_oe ? data_pins_out : pat;
	logic [2:0] ack_h = 3'h7;
	logic [9:0] st_h = 10'h3FF;
	logic [15:0] din_h = 16'h0000;
	ppsi_ctl_t ctl_h = '0;
	logic mon = 1'b0, tx_p = 1'b0, so_p = 1'b0;
	logic [DATA_W-1:0] exp_q[$];
	int error_cnt = 0, check_count = 0, seed = 35, cnt = 0, n = 0;

	ppsi_top ppsi_top_inst (.clk_sys(clk_sys), .resetn(resetn), .ctl(ctl), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .status_pins(status_pins),
		.data_pins_in(data_pins_in), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
		.status_sync(status_sync), .data_sampled(data_sampled), .tx_active(tx_active),
		.data_strobe_out_n(data_strobe_out_n), .data_strobe_oe(data_strobe_oe),
		.auto_feed_out_n(auto_feed_out_n), .auto_feed_oe(auto_feed_oe), .init_out_n(init_out_n),
		.init_oe(init_oe), .select_out_n(select_out_n), .select_oe(select_oe),
		.host_interrupt_out_n(host_interrupt_out_n), .host_interrupt_oe(host_interrupt_oe));
	ppsi_printer_model ppsi_printer_model_inst (.clk_sys(clk_sys), .strobe_n(~data_strobe_oe),
		.init_n(~init_oe), .data_wire(data_pins_in), .hold_busy(hold_busy),
		.busy_len(busy_len), .cond(cond), .status(status_pins), .pat(pat),
		.cap_valid(cap_valid), .cap_data(cap_data), .overrun(overrun));

	always #25 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : check
	// open-drain pins read low exactly while their enable is high
	function automatic logic [4:0] lines_n(input logic [4:0] oe);
		return ~oe;
	endfunction : lines_n
	function automatic logic irq_exp(input ppsi_ctl_t c, input logic ack_n);
		return c.standard_printer_mode && c.irq_enable && !ack_n;
	endfunction : irq_exp
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	// offers random bytes for a number of cycles, n counts the ones taken
	task automatic push(input int cycles);
		n = 0;
		wr_valid <= 1'b1;
		wr_data <= 8'($random(seed));
		repeat (cycles) begin
			@(posedge clk_sys);
			if (wr_ready === 1'b1) begin
				exp_q.push_back(wr_data);
				n++;
				wr_data <= 8'($random(seed));
			end
		end
		wr_valid <= 1'b0;
	endtask : push
	task automatic drain();
		for (int i = 0; i < 9000 && exp_q.size() != 0; i++)
			@(posedge clk_sys);
		check(16'(exp_q.size()), 16'h0000, "bytes lost");
	endtask : drain
	////////////////////////////////////////////////////////////////////////
	// pin histories give the expected two- and three-edge latencies
	always @(posedge clk_sys) begin
		ack_h <= {ack_h[1:0], status_pins.transfer_ack_in_n};
		st_h <= {st_h[4:0], status_pins};
		din_h <= {din_h[7:0], data_pins_in};
		ctl_h <= ctl;
	end
	always @(negedge clk_sys) begin
		if (cap_valid) begin
			check(cap_data, exp_q.pop_front(), "printed byte");
			busy_len <= 8'($random(seed)) & 8'h3F;
		end
		if (mon) begin
			check(status_sync, st_h[9:5], "status sync");
			check(data_sampled, din_h[15:8], "data sample");
			check({auto_feed_oe, init_oe, select_oe}, {ctl_h.auto_feed, ctl_h.init, ctl_h.select}, "ctl");
			check({auto_feed_out_n, init_out_n, select_out_n, host_interrupt_out_n, data_strobe_out_n},
				lines_n({auto_feed_oe, init_oe, select_oe, host_interrupt_oe, data_strobe_oe}), "level");
			check(host_interrupt_oe, irq_exp(ctl_h, ack_h[2]), "irq");
			cnt = (tx_active && !tx_p) ? 0 : cnt + 1;
			if (data_strobe_oe && !so_p) check(16'(cnt), SETUP_CYC, "setup");
			if (!data_strobe_oe && so_p) check(16'(cnt), SETUP_CYC + PULSE_CYC, "pulse");
			if (!tx_active && tx_p) check(16'(cnt), SETUP_CYC + PULSE_CYC + HOLD_CYC, "hold");
		end
		tx_p = tx_active;
		so_p = data_strobe_oe;
	end
	initial begin
		#1000000;
		error_cnt++;
		results();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (11) @(posedge clk_sys);
		@(negedge clk_sys);
		check({data_pins_oe, tx_active, data_strobe_oe, status_sync}, 16'h001F, "reset");
		@(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		mon <= 1'b1;
		repeat (48) begin
			ctl <= ppsi_ctl_t'(6'($random(seed)));
			cond <= 3'($random(seed));
			repeat (4) @(posedge clk_sys);
			if (ctl.dir_input) check(data_pins_oe, 1'b0, "released");
		end
		$display("control and status test done");
		ctl <= 6'h32;
		cond <= 3'h0;
		repeat (4) @(posedge clk_sys);
		ctl <= 6'h33;
		push(4);
		repeat (80) @(posedge clk_sys);
		check(tx_active, 1'b0, "input direction");
		ctl <= 6'h32;
		drain();
		$display("direction test done");
		hold_busy <= 1'b1;
		repeat (5) @(posedge clk_sys);
		push(30);
		check(16'(n), 16'(FIFO_DEPTH + 1), "fill");
		hold_busy <= 1'b0;
		// the lowered valid stands for one edge before the next offer
		@(posedge clk_sys);
		push(300);
		drain();
		check(overrun, 1'b0, "strobe while busy");
		$display("print test done");
		results();
	end
endmodule : tb_ppsi_top
`default_nettype wire
